// ---- hdl/dfp_defines.vh ----
// constants for the dsx-1 port failure policy block
// assumes inclusion by bare name from the hdl files
`ifndef DFP_DEFINES_VH
`define DFP_DEFINES_VH
// line coding values
`define DFP_CODE_AMI 1'b0
`define DFP_CODE_B8ZS 1'b1
`define DFP_CODE_RST 1'b1
// equalization ranges, 0-133 up to 533-655 feet
`define DFP_EQ_0_133 3'h0
`define DFP_EQ_133_266 3'h1
`define DFP_EQ_266_399 3'h2
`define DFP_EQ_399_533 3'h3
`define DFP_EQ_533_655 3'h4
`define DFP_EQ_MAX 3'h4
// error rate threshold, exponent 4..9 meaning 1e-4..1e-9
`define DFP_EXP_MIN 4'h4
`define DFP_EXP_MAX 4'h9
// clock source
`define DFP_CLK_INTERNAL 1'b0
`define DFP_CLK_RECOVERED 1'b1
// dsl rate below which the recovered clock is forced, kbps
`define DFP_RATE_FORCE_KBPS 12'h610
// copy target codes
`define DFP_TGT_P1 2'h0
`define DFP_TGT_P2 2'h1
`define DFP_TGT_ALL 2'h2
// config word fields
`define DFP_CFG_W 10
`define DFP_CFG_CODE 0
`define DFP_CFG_EQ_LO 1
`define DFP_CFG_EQ_HI 3
`define DFP_CFG_EXP_LO 4
`define DFP_CFG_EXP_HI 7
`define DFP_CFG_AIS 8
`define DFP_CFG_ONES 9
`define DFP_CFG_RST 10'h341
`endif

// ---- hdl/dfp_line_code.v ----
// ami / b8zs line coder for one dsx-1 port
// assumes one bit per clk when bit_valid, codes chosen per port
`timescale 1ns/10ps
`include "dfp_defines.vh"
module dfp_line_code (
  clk,
  reset_n,
  b8zs_en,
  bit_valid,
  tx_bit,
  tx_pos_ff,
  tx_neg_ff,
  rx_pos,
  rx_neg,
  rx_bit_ff
);
  input wire clk;
  input wire reset_n;
  input wire b8zs_en;
  input wire bit_valid;
  input wire tx_bit;
  output reg tx_pos_ff;
  output reg tx_neg_ff;
  input wire rx_pos;
  input wire rx_neg;
  output reg rx_bit_ff;

  reg [7:0] dly_ff;
  reg last_pol_ff;
  reg [2:0] sub_cnt_ff;
  reg [7:0] rx_pat_ff;
  reg [2:0] rx_pol_ff;
  reg nxt_pol;
  reg nxt_pos;
  reg nxt_neg;
  reg [2:0] nxt_sub;

  ////////////////////////////////////////////////////////////////////
  // encoder: marks alternate, eight zeros replaced by 000VB0VB
  always @* begin
    nxt_pol = last_pol_ff;
    nxt_pos = 1'b0;
    nxt_neg = 1'b0;
    nxt_sub = sub_cnt_ff;
    if (sub_cnt_ff != 3'h0) begin
      // slots 2..8 of the substitution: 0 0 V B 0 V B
      nxt_sub = sub_cnt_ff - 3'h1;
      case (sub_cnt_ff)
        3'h5, 3'h2: begin
          nxt_pos = last_pol_ff;
          nxt_neg = ~last_pol_ff;
        end
        3'h4, 3'h1: begin
          nxt_pos = ~last_pol_ff;
          nxt_neg = last_pol_ff;
          nxt_pol = ~last_pol_ff;
        end
        default: begin
          nxt_pos = 1'b0;
        end
      endcase
    end else if (dly_ff[7]) begin
      nxt_pol = ~last_pol_ff;
      nxt_pos = ~last_pol_ff;
      nxt_neg = last_pol_ff;
    end else if (b8zs_en && dly_ff == 8'h00) begin
      nxt_sub = 3'h7; // eight zeros queued, slot 1 goes out as zero
    end
  end

  // eight-bit delay shows a whole zero run before its first slot is sent
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_ff <= 8'h00;
      last_pol_ff <= 1'b0;
      sub_cnt_ff <= 3'h0;
      tx_pos_ff <= 1'b0;
      tx_neg_ff <= 1'b0;
    end else if (bit_valid) begin
      dly_ff <= {dly_ff[6:0], tx_bit};
      last_pol_ff <= nxt_pol;
      sub_cnt_ff <= nxt_sub;
      tx_pos_ff <= nxt_pos;
      tx_neg_ff <= nxt_neg;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // decoder window; plain ami alternates slots 5 and 7, b8zs repeats them
  wire [7:0] rx_win = {rx_pat_ff[6:0], rx_pos | rx_neg};
  wire rx_sub = b8zs_en && rx_win == 8'h1B && rx_pol_ff[2] == rx_pol_ff[0];

  // decoder: any pulse is a one, b8zs pattern 000VB0VB restored to zeros
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_pat_ff <= 8'h00;
      rx_pol_ff <= 3'h0;
      rx_bit_ff <= 1'b0;
    end else if (bit_valid) begin
      rx_pat_ff <= rx_sub ? 8'h00 : rx_win;
      rx_pol_ff <= {rx_pol_ff[1:0], rx_pos};
      rx_bit_ff <= rx_pat_ff[7];
    end
  end
endmodule

// ---- hdl/dfp_err_rate.v ----
// excessive error rate monitor for one port
// assumes crc_err and bit_valid are single-cycle pulses on clk
`timescale 1ns/10ps
`include "dfp_defines.vh"
module dfp_err_rate #(
  parameter WIN_BITS = 40
) (
  clk,
  reset_n,
  thr_exp,
  bit_valid,
  crc_err,
  exceeded_ff
);
  input wire clk;
  input wire reset_n;
  input wire [3:0] thr_exp;
  input wire bit_valid;
  input wire crc_err;
  output reg exceeded_ff;

  reg [WIN_BITS-1:0] bits_ff;
  reg [WIN_BITS-1:0] errs_ff;

  // ten to the power of the exponent, bits per allowed error
  function [WIN_BITS-1:0] pow10;
    input [3:0] e;
    begin
      case (e)
        4'h4: pow10 = 40'd10000;
        4'h5: pow10 = 40'd100000;
        4'h6: pow10 = 40'd1000000;
        4'h7: pow10 = 40'd10000000;
        4'h8: pow10 = 40'd100000000;
        4'h9: pow10 = 40'd1000000000;
        default: pow10 = 40'd10000;
      endcase
    end
  endfunction

  wire [WIN_BITS-1:0] period = pow10(thr_exp);

  ////////////////////////////////////////////////////////////////////
  // measurement period of 10^n bits; flag holds until a period ends low
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits_ff <= {WIN_BITS{1'b0}};
      errs_ff <= {WIN_BITS{1'b0}};
      exceeded_ff <= 1'b0;
    end else begin
      if (bit_valid && bits_ff >= period - 1'b1) begin
        bits_ff <= {WIN_BITS{1'b0}};
        errs_ff <= {WIN_BITS{1'b0}};
        // rate = errs/bits >= 1/10^n, i.e. at least one error
        exceeded_ff <= (errs_ff + crc_err) != 0;
      end else begin
        if (bit_valid)
          bits_ff <= bits_ff + 1'b1;
        if (crc_err && errs_ff != {WIN_BITS{1'b1}})
          errs_ff <= errs_ff + 1'b1;
        if (crc_err && errs_ff != 0)
          exceeded_ff <= 1'b1; // reached early within period
      end
    end
  end
endmodule

// ---- hdl/dfp_port_policy.v ----
// dsx-1 port failure policy: coding, error rate, failure substitution,
// clock source and configuration copy for a number of tributary ports
// assumes line, status and enable pins are asynchronous and synchronised here; config, copy and clock inputs are used unsynchronised
// Operation
// - each port codes and decodes the line with ami or b8zs as configured.
// - each port holds one of five equalization ranges, reset to the shortest.
// - the error threshold is selectable from 1e-4 to 1e-9, reset to 1e-4.
// - crc failures over bits in a period decide the excessive error condition.
// - with ais enabled, network signal or frame loss sends ais to the dsx-1.
// - with a substitution disabled the failed signal passes through unchanged.
// - with all-ones enabled, dsx-1 signal or framing loss sends ones to network.
// - primary clock is the internal oscillator or the recovered dsx-1 clock.
// - below 1552 kbps in line role the recovered clock is forced.
// - a copy replaces a target port's config (one, two or all) from a source.
// - copy-then-increment advances the target port number by one.
// - a copy never touches the peer address or circuit identifier.
// - a disabled port raises no alarm, keeps its lamp off and takes no config.
`timescale 1ns/10ps
`include "dfp_defines.vh"
module dfp_port_policy #(
  parameter NPORT = 2
) (
  clk,
  reset_n,
  port_enable,
  cfg_wr,
  cfg_port,
  cfg_data,
  copy_go,
  copy_incr,
  copy_src,
  copy_tgt,
  copy_busy_ff,
  copy_tgt_ff,
  line_side_control_role,
  dsl_rate_kbps,
  clk_src_req,
  clk_src_ff,
  bit_valid,
  frame_start,
  net_rx_bit,
  dsx_tx_pos_ff,
  dsx_tx_neg_ff,
  dsx_rx_pos,
  dsx_rx_neg,
  net_tx_bit_ff,
  crc_err,
  net_signal_loss,
  frame_alignment_lost,
  dsx_signal_loss,
  framing_loss,
  cfg_ff,
  error_rate_exceeded_ff,
  ais_active_ff,
  ones_active_ff,
  lamp_on_ff
);
  input wire clk;
  input wire reset_n;
  input wire [NPORT-1:0] port_enable;
  input wire cfg_wr;
  input wire [1:0] cfg_port;
  input wire [`DFP_CFG_W-1:0] cfg_data;
  input wire copy_go;
  input wire copy_incr;
  input wire [1:0] copy_src;
  input wire [1:0] copy_tgt;
  output reg copy_busy_ff;
  output reg [1:0] copy_tgt_ff;
  input wire line_side_control_role;
  input wire [11:0] dsl_rate_kbps;
  input wire clk_src_req;
  output reg clk_src_ff;
  input wire [NPORT-1:0] bit_valid;
  input wire [NPORT-1:0] frame_start;
  input wire [NPORT-1:0] net_rx_bit;
  output wire [NPORT-1:0] dsx_tx_pos_ff;
  output wire [NPORT-1:0] dsx_tx_neg_ff;
  input wire [NPORT-1:0] dsx_rx_pos;
  input wire [NPORT-1:0] dsx_rx_neg;
  output reg [NPORT-1:0] net_tx_bit_ff;
  input wire [NPORT-1:0] crc_err;
  input wire [NPORT-1:0] net_signal_loss;
  input wire [NPORT-1:0] frame_alignment_lost;
  input wire [NPORT-1:0] dsx_signal_loss;
  input wire [NPORT-1:0] framing_loss;
  output reg [NPORT*`DFP_CFG_W-1:0] cfg_ff;
  output reg [NPORT-1:0] error_rate_exceeded_ff;
  output reg [NPORT-1:0] ais_active_ff;
  output reg [NPORT-1:0] ones_active_ff;
  output reg [NPORT-1:0] lamp_on_ff;

  // copy machine states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_COPY = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  reg [2:0] state_ff;
  reg [1:0] src_ff;
  reg incr_ff;

  // pin synchronisers, two stages
  reg [NPORT*6-1:0] pin_s1_ff;
  reg [NPORT*6-1:0] pin_s2_ff;
  reg [NPORT*5-1:0] ctl_s1_ff;
  reg [NPORT*5-1:0] ctl_s2_ff;

  // decode a target code into a per-port hit mask
  function [NPORT-1:0] tgt_mask;
    input [1:0] code;
    integer k;
    begin
      for (k = 0; k < NPORT; k = k + 1)
        tgt_mask[k] = (code == `DFP_TGT_ALL) || (code == k[1:0]);
    end
  endfunction

  // sanitise a config word: out-of-range equalization and threshold fields fall back to reset defaults
  function [`DFP_CFG_W-1:0] clean_cfg;
    input [`DFP_CFG_W-1:0] w;
    begin
      clean_cfg = w;
      if (w[`DFP_CFG_EQ_HI:`DFP_CFG_EQ_LO] > `DFP_EQ_MAX)
        clean_cfg[`DFP_CFG_EQ_HI:`DFP_CFG_EQ_LO] = `DFP_EQ_0_133;
      if (w[`DFP_CFG_EXP_HI:`DFP_CFG_EXP_LO] < `DFP_EXP_MIN ||
          w[`DFP_CFG_EXP_HI:`DFP_CFG_EXP_LO] > `DFP_EXP_MAX)
        clean_cfg[`DFP_CFG_EXP_HI:`DFP_CFG_EXP_LO] = `DFP_EXP_MIN;
    end
  endfunction

  // ports written by the copy in progress
  wire [NPORT-1:0] copy_hit = tgt_mask(copy_tgt_ff);

  ////////////////////////////////////////////////////////////////////
  // synchronise line pins and failure status from outside
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_ff <= {NPORT*6{1'b0}};
      pin_s2_ff <= {NPORT*6{1'b0}};
      ctl_s1_ff <= {NPORT*5{1'b0}};
      ctl_s2_ff <= {NPORT*5{1'b0}};
    end else begin
      pin_s1_ff <= {dsx_rx_pos, dsx_rx_neg, net_signal_loss, frame_alignment_lost,
                    dsx_signal_loss, framing_loss};
      pin_s2_ff <= pin_s1_ff;
      ctl_s1_ff <= {port_enable, crc_err, net_rx_bit, bit_valid, frame_start};
      ctl_s2_ff <= ctl_s1_ff;
    end
  end

  wire [NPORT-1:0] rx_pos_s = pin_s2_ff[6*NPORT-1:5*NPORT];
  wire [NPORT-1:0] rx_neg_s = pin_s2_ff[5*NPORT-1:4*NPORT];
  wire [NPORT-1:0] nlos_s = pin_s2_ff[4*NPORT-1:3*NPORT];
  wire [NPORT-1:0] noof_s = pin_s2_ff[3*NPORT-1:2*NPORT];
  wire [NPORT-1:0] dlos_s = pin_s2_ff[2*NPORT-1:NPORT];
  wire [NPORT-1:0] dlof_s = pin_s2_ff[NPORT-1:0];
  wire [NPORT-1:0] en_s = ctl_s2_ff[5*NPORT-1:4*NPORT];
  wire [NPORT-1:0] crc_s = ctl_s2_ff[4*NPORT-1:3*NPORT];
  wire [NPORT-1:0] nrx_s = ctl_s2_ff[3*NPORT-1:2*NPORT];
  wire [NPORT-1:0] bv_s = ctl_s2_ff[2*NPORT-1:NPORT];
  wire [NPORT-1:0] fs_s = ctl_s2_ff[NPORT-1:0];

  ////////////////////////////////////////////////////////////////////
  // copy sequencer: latch source port and target, then write every enabled target
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_IDLE;
      copy_busy_ff <= 1'b0;
      copy_tgt_ff <= `DFP_TGT_P2;
      src_ff <= `DFP_TGT_P1;
      incr_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (copy_go) begin
            src_ff <= (copy_src == `DFP_TGT_P2) ? `DFP_TGT_P2 : `DFP_TGT_P1;
            copy_tgt_ff <= copy_tgt;
            incr_ff <= copy_incr;
            copy_busy_ff <= 1'b1;
            state_ff <= ST_COPY;
          end
        end
        ST_COPY: begin
          state_ff <= ST_DONE;
        end
        ST_DONE: begin
          // step to the next port, wrap back to the first
          if (incr_ff && copy_tgt_ff != `DFP_TGT_ALL)
            copy_tgt_ff <= (copy_tgt_ff == NPORT - 1) ? `DFP_TGT_P1 :
                           copy_tgt_ff + 2'h1;
          copy_busy_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
          copy_busy_ff <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // clock source: only in line role; forced recovered at low dsl rates
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      clk_src_ff <= `DFP_CLK_INTERNAL;
    else if (line_side_control_role) begin
      if (dsl_rate_kbps < `DFP_RATE_FORCE_KBPS)
        clk_src_ff <= `DFP_CLK_RECOVERED;
      else
        clk_src_ff <= clk_src_req;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // per-port datapath and policy
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      wire [`DFP_CFG_W-1:0] my_cfg = cfg_ff[g*`DFP_CFG_W +: `DFP_CFG_W];
      wire [`DFP_CFG_W-1:0] src_cfg = cfg_ff[src_ff[0]*`DFP_CFG_W +: `DFP_CFG_W];
      wire dec_bit;
      wire rate_hit;
      wire net_fail = nlos_s[g] | noof_s[g];
      wire dsx_fail = dlos_s[g] | dlof_s[g];
      reg ais_pend_ff;
      reg ones_pend_ff;

      // configuration store, locked while the port is disabled
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n)
          cfg_ff[g*`DFP_CFG_W +: `DFP_CFG_W] <= `DFP_CFG_RST;
        else if (en_s[g]) begin
          if (state_ff == ST_COPY && copy_hit[g])
            cfg_ff[g*`DFP_CFG_W +: `DFP_CFG_W] <= src_cfg;
          else if (cfg_wr && cfg_port == g)
            cfg_ff[g*`DFP_CFG_W +: `DFP_CFG_W] <= clean_cfg(cfg_data);
        end
      end

      // coder toward dsx-1 sends ais (all ones) when active
      dfp_line_code u_code (
        .clk(clk),
        .reset_n(reset_n),
        .b8zs_en(my_cfg[`DFP_CFG_CODE]),
        .bit_valid(bv_s[g]),
        .tx_bit(nrx_s[g] | ais_active_ff[g]),
        .tx_pos_ff(dsx_tx_pos_ff[g]),
        .tx_neg_ff(dsx_tx_neg_ff[g]),
        .rx_pos(rx_pos_s[g]),
        .rx_neg(rx_neg_s[g]),
        .rx_bit_ff(dec_bit)
      );

      dfp_err_rate u_err (
        .clk(clk),
        .reset_n(reset_n),
        .thr_exp(my_cfg[`DFP_CFG_EXP_HI:`DFP_CFG_EXP_LO]),
        .bit_valid(bv_s[g]),
        .crc_err(crc_s[g]),
        .exceeded_ff(rate_hit)
      );

      // substitution begins on the next frame, ends on recovery
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          ais_pend_ff <= 1'b0;
          ones_pend_ff <= 1'b0;
          ais_active_ff[g] <= 1'b0;
          ones_active_ff[g] <= 1'b0;
          net_tx_bit_ff[g] <= 1'b0;
          error_rate_exceeded_ff[g] <= 1'b0;
          lamp_on_ff[g] <= 1'b0;
        end else begin
          ais_pend_ff <= net_fail & my_cfg[`DFP_CFG_AIS] & en_s[g];
          ones_pend_ff <= dsx_fail & my_cfg[`DFP_CFG_ONES] & en_s[g];
          if (!ais_pend_ff)
            ais_active_ff[g] <= 1'b0;
          else if (fs_s[g])
            ais_active_ff[g] <= 1'b1;
          if (!ones_pend_ff)
            ones_active_ff[g] <= 1'b0;
          else if (fs_s[g])
            ones_active_ff[g] <= 1'b1;
          net_tx_bit_ff[g] <= ones_active_ff[g] | dec_bit;
          error_rate_exceeded_ff[g] <= rate_hit & en_s[g];
          lamp_on_ff[g] <= en_s[g];
        end
      end
    end
  endgenerate
endmodule

// ---- dv/dfp_port_policy_asserts.sv ----
// checker for the dsx-1 port failure policy block: clock and copy paths, config of all ports, port 0 substitution and lamp
// assumes binding onto dfp_port_policy, single clk domain
`timescale 1ns/10ps
module dfp_port_policy_asserts #(
  parameter NPORT = 2
) (
  input wire clk,
  input wire reset_n,
  input wire [NPORT-1:0] port_enable,
  input wire cfg_wr,
  input wire copy_busy_ff,
  input wire [1:0] copy_tgt_ff,
  input wire line_side_control_role,
  input wire [11:0] dsl_rate_kbps,
  input wire clk_src_req,
  input wire clk_src_ff,
  input wire [NPORT-1:0] net_signal_loss,
  input wire [NPORT-1:0] frame_alignment_lost,
  input wire [NPORT-1:0] dsx_signal_loss,
  input wire [NPORT-1:0] framing_loss,
  input wire [NPORT*10-1:0] cfg_ff,
  input wire [NPORT-1:0] ais_active_ff,
  input wire [NPORT-1:0] ones_active_ff,
  input wire [NPORT-1:0] net_tx_bit_ff,
  input wire [NPORT-1:0] lamp_on_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////
  // clock source choice
  chk_clk_forced: assert property (
    (line_side_control_role && dsl_rate_kbps < 12'h610)[*5] |-> clk_src_ff)
    else $error("recovered clock not forced at low rate");
  chk_clk_internal: assert property (
    (line_side_control_role && dsl_rate_kbps >= 12'h610 && !clk_src_req)[*5]
    |-> !clk_src_ff) else $error("internal clock not chosen");
  // copy sequencing and config causes
  chk_copy_busy: assert property (
    $rose(copy_busy_ff) |=> copy_busy_ff ##1 !copy_busy_ff)
    else $error("copy busy not two cycles");
  chk_tgt_cause: assert property (
    $changed(copy_tgt_ff) |-> copy_busy_ff || $past(copy_busy_ff))
    else $error("copy target moved outside a copy");
  chk_cfg_cause: assert property (
    $changed(cfg_ff) |-> $past(cfg_wr) || $past(copy_busy_ff))
    else $error("config changed without write or copy");
  // substitution policy
  chk_ais_off: assert property (
    (!cfg_ff[8])[*4] |-> !ais_active_ff[0]) else $error("ais while disabled");
  chk_ais_stop: assert property (
    (!net_signal_loss[0] && !frame_alignment_lost[0])[*6] |-> !ais_active_ff[0])
    else $error("ais held after recovery");
  chk_ones_stop: assert property (
    (!dsx_signal_loss[0] && !framing_loss[0])[*6] |-> !ones_active_ff[0])
    else $error("all-ones held after recovery");
  chk_ones_out: assert property (
    ones_active_ff[0] && $past(ones_active_ff[0]) |-> net_tx_bit_ff[0])
    else $error("all-ones not sent to network");
  chk_off_quiet: assert property (
    (!port_enable[0])[*6] |-> !ais_active_ff[0] && !lamp_on_ff[0])
    else $error("disabled port shows alarm or lamp");
endmodule
bind dfp_port_policy dfp_port_policy_asserts #(.NPORT(NPORT)) chk_i (
  .clk, .reset_n, .port_enable, .cfg_wr, .copy_busy_ff, .copy_tgt_ff,
  .line_side_control_role, .dsl_rate_kbps, .clk_src_req, .clk_src_ff,
  .net_signal_loss, .frame_alignment_lost, .dsx_signal_loss, .framing_loss,
  .cfg_ff, .ais_active_ff, .ones_active_ff, .net_tx_bit_ff, .lamp_on_ff);

// ---- dv/dfp_dsx_model.sv ----
// dsx-1 line equipment model: ami sender and mark counter
// assumes one line bit per clk, lines silent while the link is lost
`timescale 1ns/10ps
module dfp_dsx_model (
  input wire clk,
  input wire send_bit,
  input wire lost,
  input wire tx_pos,
  input wire tx_neg,
  output logic rx_pos,
  output logic rx_neg,
  output logic signal_loss,
  output logic framing_loss,
  output int marks,
  output int viols
);
  logic pol_ff = 1'b0;
  logic last_ff = 1'b0;
  initial begin
    marks = 0;
    viols = 0;
  end
  // ami sender, marks alternate polarity
  always @(posedge clk) begin
    rx_pos <= !lost && send_bit && !pol_ff;
    rx_neg <= !lost && send_bit && pol_ff;
    if (!lost && send_bit) pol_ff <= !pol_ff;
    signal_loss <= lost;
    framing_loss <= lost;
  end
  // count marks and same-polarity repeats seen from the unit
  always @(posedge clk) begin
    if (tx_pos || tx_neg) begin
      marks <= marks + 1;
      if (tx_pos == last_ff) viols <= viols + 1;
      last_ff <= tx_pos;
    end
  end
endmodule

// ---- dv/dfp_port_policy_tb.sv ----
// self-checking bench for the port failure policy block
// assumes a dsx-1 model on port 0, port 1 line inputs idle
`timescale 1ns/10ps
module dfp_port_policy_tb;
  logic clk, reset_n, cfg_wr, copy_go, copy_incr, line_side_control_role;
  logic clk_src_req, pd_bit, pd_lost, pd_pos, pd_neg, pd_sl, pd_fl;
  logic [1:0] port_enable, cfg_port, copy_src, copy_tgt, bit_valid, net_rx_bit;
  logic [1:0] crc_err, net_signal_loss, frame_alignment_lost, frame_start;
  logic [9:0] cfg_data;
  logic [11:0] dsl_rate_kbps;
  logic [3:0] fcnt_ff;
  wire copy_busy_ff, clk_src_ff;
  wire [1:0] copy_tgt_ff, dsx_tx_pos_ff, dsx_tx_neg_ff, net_tx_bit_ff;
  wire [1:0] error_rate_exceeded_ff, ais_active_ff, ones_active_ff, lamp_on_ff;
  wire [19:0] cfg_ff;
  wire [1:0] dsx_rx_pos = {1'b0, pd_pos};
  wire [1:0] dsx_rx_neg = {1'b0, pd_neg};
  wire [1:0] dsx_signal_loss = {1'b0, pd_sl};
  wire [1:0] framing_loss = {1'b0, pd_fl};
  int marks, viols, err_count, num_checks, m0, v0, k;
  logic [9:0] cfg_m [2];
  logic [1:0] tgt_m;
  dfp_port_policy #(.NPORT(2)) dfp_port_policy_i (.clk, .reset_n, .port_enable,
    .cfg_wr, .cfg_port, .cfg_data, .copy_go, .copy_incr, .copy_src, .copy_tgt,
    .copy_busy_ff, .copy_tgt_ff, .line_side_control_role, .dsl_rate_kbps,
    .clk_src_req, .clk_src_ff, .bit_valid, .frame_start, .net_rx_bit,
    .dsx_tx_pos_ff, .dsx_tx_neg_ff, .dsx_rx_pos, .dsx_rx_neg, .net_tx_bit_ff,
    .crc_err, .net_signal_loss, .frame_alignment_lost, .dsx_signal_loss,
    .framing_loss, .cfg_ff, .error_rate_exceeded_ff, .ais_active_ff,
    .ones_active_ff, .lamp_on_ff);
  dfp_dsx_model dfp_dsx_model_i (.clk, .send_bit(pd_bit), .lost(pd_lost),
    .tx_pos(dsx_tx_pos_ff[0]), .tx_neg(dsx_tx_neg_ff[0]), .rx_pos(pd_pos),
    .rx_neg(pd_neg), .signal_loss(pd_sl), .framing_loss(pd_fl), .marks, .viols);
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // frame strobe every 16 bits on both ports
  always @(posedge clk) begin
    fcnt_ff <= fcnt_ff + 4'h1;
    frame_start <= {2{fcnt_ff == 4'h0}};
  end
  task check(input logic [19:0] seen, input logic [19:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // settle n cycles, sample after the edge
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // bounded wait on one port 0 flag
  task wait_sig(input int w, input logic v, input int lim);
    int n;
    logic s;
    n = 0;
    s = ~v;
    while (n < lim && s !== v) begin
      tick(1);
      s = (w == 0) ? ais_active_ff[0] : (w == 1) ? ones_active_ff[0] :
        error_rate_exceeded_ff[0];
      n++;
    end
    check(s, v);
    if (s !== v) complete_run;
  endtask
  // model keeps legal fields, bad ones fall back to defaults
  function logic [9:0] clampf(input logic [9:0] d);
    clampf = d;
    if (d[3:1] > 3'h4) clampf[3:1] = 3'h0;
    if (d[7:4] < 4'h4 || d[7:4] > 4'h9) clampf[7:4] = 4'h4;
  endfunction
  task wr_cfg(input int p, input logic [9:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_port <= p[1:0];
    cfg_data <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
    if (port_enable[p]) cfg_m[p] = clampf(d);
    tick(1);
    check(cfg_ff, {cfg_m[1], cfg_m[0]});
  endtask
  task copy(input int s, input int t, input logic inc);
    @(posedge clk);
    copy_go <= 1'b1;
    copy_src <= s[1:0];
    copy_tgt <= t[1:0];
    copy_incr <= inc;
    @(posedge clk);
    copy_go <= 1'b0;
    if (t != 1) cfg_m[0] = cfg_m[s];
    if (t != 0) cfg_m[1] = cfg_m[s];
    tgt_m = (inc && t != 2) ? (t + 1) % 2 : t;
    tick(4);
    check(cfg_ff, {cfg_m[1], cfg_m[0]});
    check(copy_tgt_ff, tgt_m);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    {reset_n, cfg_wr, copy_go, copy_incr, line_side_control_role, clk_src_req} = 0;
    {pd_bit, pd_lost, cfg_port, copy_src, copy_tgt, net_rx_bit, crc_err} = 0;
    {net_signal_loss, frame_alignment_lost, frame_start, cfg_data} = 0;
    {dsl_rate_kbps, fcnt_ff} = 0;
    port_enable = 2'b11;
    bit_valid = 2'b11;
    err_count = 0;
    num_checks = 0;
    void'($urandom(36));
    tick(2);
    reset_n <= 1'b1;
    tick(1);
    // default: b8zs, shortest range, 1e-4, both substitutions on
    cfg_m[0] = 10'h341;
    cfg_m[1] = 10'h341;
    check(cfg_ff, {cfg_m[1], cfg_m[0]});
    check(copy_tgt_ff, 2'h1);
    check(clk_src_ff, 1'b0);
    repeat (12) wr_cfg($urandom % 2, $urandom);
    port_enable <= 2'b10;
    net_signal_loss <= 2'b01;
    tick(40);
    check({ais_active_ff[0], lamp_on_ff[0]}, 2'b00);
    wr_cfg(0, 10'h3FF);
    port_enable <= 2'b11;
    net_signal_loss <= 2'b00;
    tick(4);
    copy(0, 1, 1'b1);
    wr_cfg(0, $urandom);
    copy(1, 0, 1'b0);
    wr_cfg(1, $urandom);
    copy(1, 2, 1'b1);
    // clock table: forced, requested, internal, not line role
    for (k = 0; k < 4; k++) begin
      line_side_control_role <= (k != 3);
      dsl_rate_kbps <= (k == 0) ? 12'h3E8 : 12'h610;
      clk_src_req <= k[0];
      tick(6);
      check(clk_src_ff, k < 2);
    end
    // ami ones then b8zs zeros toward the dsx-1 line
    wr_cfg(0, 10'h390);
    net_rx_bit <= 2'b11;
    pd_bit <= 1'b1;
    tick(20);
    {m0, v0} = {marks, viols};
    tick(48);
    check(marks - m0, 48);
    check(viols - v0, 0);
    check(net_tx_bit_ff[0], 1'b1);
    wr_cfg(0, 10'h391);
    net_rx_bit <= 2'b00;
    tick(20);
    {m0, v0} = {marks, viols};
    tick(48);
    check(marks - m0, 24);
    check(viols - v0, 12);
    // ais on each network failure kind
    for (k = 0; k < 2; k++) begin
      net_signal_loss <= {1'b0, k == 0};
      frame_alignment_lost <= {1'b0, k == 1};
      wait_sig(0, 1'b1, 100);
      tick(12);
      m0 = marks;
      tick(16);
      check(marks - m0, 16);
      {net_signal_loss, frame_alignment_lost} <= 4'h0;
      wait_sig(0, 1'b0, 10);
    end
    pd_lost <= 1'b1;
    wait_sig(1, 1'b1, 100);
    tick(1);
    check(net_tx_bit_ff[0], 1'b1);
    pd_lost <= 1'b0;
    wait_sig(1, 1'b0, 10);
    // substitutions off: failed signal passes unchanged
    wr_cfg(0, 10'h091);
    {pd_lost, net_signal_loss} <= 3'h5;
    tick(40);
    check({ais_active_ff[0], ones_active_ff[0], net_tx_bit_ff[0]}, 3'h0);
    {pd_lost, net_signal_loss} <= 3'h0;
    // two two-cycle crc bursts in one period raise the flag, a clean period drops it
    wr_cfg(0, 10'h341);
    crc_err <= 2'b01;
    tick(2);
    crc_err <= 2'b00;
    tick(2);
    crc_err <= 2'b01;
    tick(2);
    crc_err <= 2'b00;
    wait_sig(2, 1'b1, 100);
    wait_sig(2, 1'b0, 30000);
    complete_run;
  end
endmodule
